// ### verilog/sws_supervisor.sv
// Supply and watchdog supervisor with Avalon-MM register access
//
// Behaviour
// - Stop-mode watchdog disable needs two keys, normal mode
// - Sequence violation clears the second key
// - Stop trigger or normal return restarts watchdog, clears keys
// - Key A already set is cleared on restart
// - Bus wake in stop restarts disabled watchdog
// - Bus-wake start enable writable only in normal
// - Wake raises interrupt, pulls receive output low
// - Power-on reset sets flag, defaults all registers
// - Reset output held until rail good plus delay
// - Supply below power-on level resets everything
// - Supply low flag; aux regulator off unless kept
// - Supply low suspends rail short-circuit protection
// - Switch supply low disables LIN, sets flag
// - Switch supply high sets flag only
// - Rail prewarning sets flag only
// - Rail low drives reset, flag, restart
// - Fourth rail-low event forces fail-safe
// - Counter clears on fail-safe, flag clear, soft reset
// - Rail overvoltage flag, init and normal only
// - Overvoltage restart with pin high, auto-clear enable
// - Overvoltage restart with pin low enters fail-safe
// - Long open window lasts 200 ms
// - Mode field write 11 requests soft reset
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module sws_supervisor #(
	parameter int unsigned LONG_WINDOW_CYCLES = sws_pkg::LONG_WINDOW_CYC,
	parameter int unsigned RESET_DELAY_CYCLES = sws_pkg::RESET_DELAY_CYC
) (
	input  wire logic                      core_clk_in,
	input  wire logic                      rst_n_in,
	// Avalon-MM slave
	input  wire logic [4:0]                avs_address_in,
	input  wire logic                      avs_read_in,
	input  wire logic                      avs_write_in,
	input  wire logic [31:0]               avs_writedata_in,
	output var  logic [31:0]               avs_readdata_out,
	output var  logic                      avs_waitrequest_out,
	// Mode from the mode state machine, same clock
	input  wire logic [2:0]                sbc_mode_in,
	// Analogue comparators and pins, asynchronous
	input  wire logic [sws_pkg::IN_W-1:0]  monitor_in,
	// Supervision outputs
	output var  logic                      reset_output_n_out,
	output var  logic                      failure_outputs_out,
	output var  logic                      restart_req_out,
	output var  logic                      failsafe_req_out,
	output var  logic                      soft_reset_out,
	output var  logic                      wdog_enabled_out,
	output var  logic                      wdog_start_out,
	output var  logic                      long_window_out,
	output var  logic                      wake_irq_out,
	output var  logic                      can_rxd_low_out,
	output var  logic [1:0]                lin_rxd_low_out,
	output var  logic                      lin_disable_out,
	output var  logic                      aux_regulator_off_out,
	output var  logic                      main_rail_sc_en_out
);
	import sws_pkg::*;

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [IN_W-1:0]  s1;            // Synchroniser stage one
		logic [IN_W-1:0]  s2;            // Stage two
		logic [IN_W-1:0]  s3;            // Stage three
		logic [IN_W-1:0]  flt;           // Accepted levels
		sws_rst_t         rst_st;        // Reset output sequencer
		logic [CNT_W-1:0] rd_cnt;        // Reset delay count
		logic [CNT_W-1:0] lw_cnt;        // Long window count
		logic             key_a;         // stop_wd_disable_key_a
		logic             key_b;         // stop_wd_disable_key_b
		logic             bus_start_en;  // bus_wake_wdog_start_en
		logic             aux_keep;      // aux_reg_keep_on_low_supply
		logic             ov_rst_en;     // main_rail_high_restart_en
		logic [7:0]       flags;         // Sticky status
		logic [2:0]       uv_cnt;        // Rail-low event count
		logic [2:0]       prev_mode;     // Mode one cycle ago
		logic             wd_on;         // Watchdog running
		logic             lw_act;        // Long window running
		logic             reset_n;       // reset_output level
		logic             fail_out;      // failure_outputs level
		logic             restart_req;   // Pulse
		logic             failsafe_req;  // Pulse
		logic             wd_start;      // Pulse
		logic             soft_rst;      // Pulse
		logic             wake_irq;      // Pulse
		logic             can_rxd_low;   // CAN receive held low
		logic [1:0]       lin_rxd_low;   // LIN receive held low
		logic             lin_dis;       // LIN transceivers off
		logic             aux_off;       // Aux regulator off
		logic             sc_en;         // Rail short-circuit protection on
		logic             avs_wait;      // Waitrequest level
		logic [31:0]      rdata;         // Read data
	} sws_state_t;

	sws_state_t st;       // Registered state
	sws_state_t next_st;  // Next state

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Software-visible registers back to their power-on values
	function automatic sws_state_t reg_defaults(input sws_state_t s);
		sws_state_t r;
		r = s;
		r.key_a        = 1'b0;
		r.key_b        = 1'b0;
		r.bus_start_en = BUS_START_RST;
		r.aux_keep     = 1'b0;
		r.ov_rst_en    = 1'b0;
		r.flags        = 8'h00;
		r.uv_cnt       = 3'h0;
		r.fail_out     = 1'b0;
		return r;
	endfunction

	// Whole state at reset
	function automatic sws_state_t reset_value();
		sws_state_t r;
		r = '0;
		r.rst_st   = RS_HOLD;
		r.avs_wait = 1'b1;
		r.sc_en    = 1'b1;
		r.wd_on    = 1'b1;
		r = reg_defaults(r);
		return r;
	endfunction

	// Write-one-to-clear, blocked while the cause persists
	function automatic logic flag_clr(input logic wr, input logic d, input logic busy);
		return wr & d & ~busy;
	endfunction

	// Register read mux
	function automatic logic [31:0] read_reg(input sws_state_t s, input logic [4:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			OFS_WAKE_CTRL: begin
				r[WK_KEY_A_BIT]     = s.key_a;
				r[WK_BUS_START_BIT] = s.bus_start_en;
				r[WK_AUX_KEEP_BIT]  = s.aux_keep;
			end
			OFS_WDOG_CFG:  r[WD_KEY_B_BIT] = s.key_b;
			OFS_MODE_CTRL: r[MC_OV_RST_BIT] = s.ov_rst_en;
			OFS_STATUS:    r[7:0] = s.flags;
			OFS_STATE:     r[9:0] = {s.uv_cnt, s.wd_on, s.lw_act, s.reset_n,
						s.fail_out, s.rst_st};
			default:       r = 32'h0000_0000;  // Unmapped reads zero
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic [IN_W-1:0] lv;     // Accepted levels this cycle
		logic [IN_W-1:0] rise;   // Rising edges
		logic [IN_W-1:0] fall;   // Falling edges
		logic            go;     // Bus access completes
		logic            wr;     // Write completes
		logic            trig;   // Watchdog trigger write
		logic            n_norm; // Normal mode
		logic            n_stop; // Stop mode
		logic            lw_go;  // Start long window
		logic            wake;   // Any bus wake
		logic [31:0]     d;      // Write data
		next_st = st;
		next_st.restart_req  = 1'b0;
		next_st.failsafe_req = 1'b0;
		next_st.wd_start     = 1'b0;
		next_st.soft_rst     = 1'b0;
		next_st.wake_irq     = 1'b0;
		next_st.prev_mode    = sbc_mode_in;
		lw_go = 1'b0;
		trig  = 1'b0;
		d     = avs_writedata_in;
		n_norm = (sbc_mode_in == MODE_NORMAL);
		n_stop = (sbc_mode_in == MODE_STOP);

		// Three-stage synchroniser; a change counts once stages two and three agree
		next_st.s1  = monitor_in;
		next_st.s2  = st.s1;
		next_st.s3  = st.s2;
		next_st.flt = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.flt);
		lv   = next_st.flt;
		rise = lv & ~st.flt;
		fall = ~lv & st.flt;
		wake = rise[IN_CAN_WK] | rise[IN_LIN1_WK] | rise[IN_LIN2_WK];

		// Bus handshake: one wait cycle, then the access completes
		go = (avs_read_in | avs_write_in) & ~st.avs_wait;
		wr = avs_write_in & go;
		next_st.avs_wait = st.avs_wait ? ~(avs_read_in | avs_write_in) : 1'b1;
		if (avs_read_in && st.avs_wait) begin
			next_st.rdata = read_reg(st, avs_address_in);
		end

		// Register writes
		if (wr) begin
			case (avs_address_in)
				OFS_WAKE_CTRL: begin
					// Writing key A again while set restarts the sequence
					if (d[WK_KEY_A_BIT] && st.key_a) begin
						next_st.key_a = 1'b0;
					end else begin
						next_st.key_a = d[WK_KEY_A_BIT] & n_norm;
					end
					if (n_norm) begin
						next_st.bus_start_en = d[WK_BUS_START_BIT];
					end
					next_st.aux_keep = d[WK_AUX_KEEP_BIT];
				end
				OFS_WDOG_CFG: begin
					// Key B only counts after key A, in normal mode
					if (d[WD_KEY_B_BIT] && st.key_a && n_norm) begin
						next_st.key_b = 1'b1;
					end else begin
						next_st.key_b = 1'b0;
					end
					trig = d[WD_TRIG_BIT];
				end
				OFS_MODE_CTRL: begin
					next_st.ov_rst_en = d[MC_OV_RST_BIT];
					// Soft reset honoured in normal or stop only
					if (d[MC_MODE_LSB +: 2] == SOFT_RESET_CMD && (n_norm || n_stop)) begin
						next_st = reg_defaults(next_st);
						next_st.soft_rst = 1'b1;
						next_st.uv_cnt   = 3'h0;
					end
				end
				OFS_STATUS: begin
					// Condition flags clear only once the condition has gone
					if (flag_clr(1'b1, d[FL_SUP_LOW], lv[IN_SUP_UV]))
						next_st.flags[FL_SUP_LOW] = 1'b0;
					if (flag_clr(1'b1, d[FL_SW_LOW], lv[IN_SW_UV]))
						next_st.flags[FL_SW_LOW] = 1'b0;
					if (flag_clr(1'b1, d[FL_SW_HIGH], lv[IN_SW_OV]))
						next_st.flags[FL_SW_HIGH] = 1'b0;
					if (flag_clr(1'b1, d[FL_MAIN_LOW], 1'b0)) begin
						next_st.flags[FL_MAIN_LOW] = 1'b0;
						next_st.uv_cnt = 3'h0;
					end
					next_st.flags[FL_POR]       = st.flags[FL_POR] & ~d[FL_POR];
					next_st.flags[FL_PREWARN]   = st.flags[FL_PREWARN] & ~d[FL_PREWARN];
					next_st.flags[FL_LOW_FS]    = st.flags[FL_LOW_FS] & ~d[FL_LOW_FS];
					next_st.flags[FL_MAIN_HIGH] = st.flags[FL_MAIN_HIGH] & ~d[FL_MAIN_HIGH];
				end
				default: ;  // Unmapped writes are dropped
			endcase
		end

		// ------------------------------------------------------------
		// Watchdog stop-mode handling
		// ------------------------------------------------------------
		// Entering stop with both keys turns the watchdog off
		if (n_stop && st.prev_mode != MODE_STOP && st.key_a && st.key_b) begin
			next_st.wd_on = 1'b0;
		end
		// Trigger in stop, or return to normal, restarts it
		if ((n_stop && trig && !st.wd_on) ||
		    (n_norm && st.prev_mode == MODE_STOP)) begin
			lw_go = 1'b1;
		end
		// Bus wake restarts a disabled watchdog when allowed
		if (n_stop && wake && st.bus_start_en && !st.wd_on) begin
			lw_go = 1'b1;
		end
		// Wake signalling towards the host
		if (n_stop && wake) begin
			next_st.wake_irq = 1'b1;
		end
		if (n_stop) begin
			next_st.can_rxd_low = st.can_rxd_low | rise[IN_CAN_WK];
			next_st.lin_rxd_low = st.lin_rxd_low | rise[IN_LIN2_WK:IN_LIN1_WK];
		end else begin
			next_st.can_rxd_low = 1'b0;
			next_st.lin_rxd_low = 2'h0;
		end

		// ------------------------------------------------------------
		// Supply conditions
		// ------------------------------------------------------------
		// Level flags follow the condition; set wins over clear
		next_st.flags[FL_SUP_LOW] = next_st.flags[FL_SUP_LOW] | lv[IN_SUP_UV];
		next_st.flags[FL_SW_LOW]  = next_st.flags[FL_SW_LOW] | lv[IN_SW_UV];
		next_st.flags[FL_SW_HIGH] = next_st.flags[FL_SW_HIGH] | lv[IN_SW_OV];
		next_st.aux_off = lv[IN_SUP_UV] & ~next_st.aux_keep;
		next_st.sc_en   = ~lv[IN_SUP_UV];
		next_st.lin_dis = lv[IN_SW_UV];
		if (rise[IN_WARN] && sbc_mode_in != MODE_SLEEP) begin
			next_st.flags[FL_PREWARN] = 1'b1;
		end

		// Rail undervoltage: reset, flag, restart, count
		if (rise[IN_RAIL_UV] && sbc_mode_in != MODE_SLEEP) begin
			next_st.reset_n = 1'b0;
			next_st.rst_st  = RS_HOLD;
			next_st.flags[FL_MAIN_LOW] = 1'b1;
			next_st.restart_req = 1'b1;
			// Counting pauses in normal while the supply is low
			if ((sbc_mode_in == MODE_INIT || n_stop || n_norm) &&
			    !(n_norm && lv[IN_SUP_UV])) begin
				next_st.uv_cnt = 3'(next_st.uv_cnt + 3'h1);
				if (next_st.uv_cnt == UV_FAILSAFE_CNT) begin
					next_st.failsafe_req = 1'b1;
					next_st.flags[FL_LOW_FS] = 1'b1;
					next_st.uv_cnt = 3'h0;
				end
			end
		end
		// Entry into fail-safe clears the counter
		if (sbc_mode_in == MODE_FAILSAFE && st.prev_mode != MODE_FAILSAFE) begin
			next_st.uv_cnt = 3'h0;
		end

		// Rail overvoltage, watched in init and normal only
		if (rise[IN_RAIL_OV] && (sbc_mode_in == MODE_INIT || n_norm)) begin
			next_st.flags[FL_MAIN_HIGH] = 1'b1;
			if (st.ov_rst_en) begin
				next_st.fail_out = 1'b1;
				if (lv[IN_CFG]) begin
					// Restart runs the delay even if overvoltage stays
					next_st.restart_req = 1'b1;
					next_st.ov_rst_en   = 1'b0;
					next_st.reset_n     = 1'b0;
					next_st.rst_st      = RS_DELAY;
					next_st.rd_cnt      = CNT_W'(RESET_DELAY_CYCLES);
				end else begin
					next_st.failsafe_req = 1'b1;
				end
			end
		end

		// ------------------------------------------------------------
		// Reset output sequencer
		// ------------------------------------------------------------
		case (next_st.rst_st)
			RS_HOLD: begin
				next_st.reset_n = 1'b0;
				// Wait for the rail to come good before timing
				if (!lv[IN_RAIL_UV] && !lv[IN_POR]) begin
					next_st.rst_st = RS_DELAY;
					next_st.rd_cnt = CNT_W'(RESET_DELAY_CYCLES);
				end
			end
			RS_DELAY: begin
				next_st.reset_n = 1'b0;
				if (next_st.rd_cnt <= CNT_W'(1)) begin
					next_st.rst_st  = RS_RUN;
					next_st.reset_n = 1'b1;
					lw_go = 1'b1;
				end else begin
					next_st.rd_cnt = CNT_W'(next_st.rd_cnt - CNT_W'(1));
				end
			end
			RS_RUN: next_st.reset_n = 1'b1;
			default: begin
				next_st.rst_st  = RS_HOLD;
				next_st.reset_n = 1'b0;
			end
		endcase

		// ------------------------------------------------------------
		// Long open window
		// ------------------------------------------------------------
		if (lw_go) begin
			next_st.wd_on    = 1'b1;
			next_st.wd_start = 1'b1;
			next_st.key_a    = 1'b0;
			next_st.key_b    = 1'b0;
			next_st.lw_cnt   = CNT_W'(LONG_WINDOW_CYCLES);
		end else if (st.lw_cnt != '0) begin
			next_st.lw_cnt = CNT_W'(st.lw_cnt - CNT_W'(1));
		end
		next_st.lw_act = (next_st.lw_cnt != '0);

		// ------------------------------------------------------------
		// Supply below power-on level: everything back to defaults
		// ------------------------------------------------------------
		if (lv[IN_POR]) begin
			next_st = reg_defaults(next_st);
			next_st.rst_st       = RS_HOLD;
			next_st.reset_n      = 1'b0;
			next_st.wd_on        = 1'b1;
			next_st.lw_cnt       = '0;
			next_st.lw_act       = 1'b0;
			next_st.restart_req  = 1'b0;
			next_st.failsafe_req = 1'b0;
		end
		// Supply back above the power-on level
		if (fall[IN_POR]) begin
			next_st.flags[FL_POR] = 1'b1;
		end

		// Fail-safe wins when both requests coincide
		if (next_st.failsafe_req) begin
			next_st.restart_req = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// State register, synchronous active-low reset
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			st <= reset_value();
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, each a state field
	// ----------------------------------------------------------------
	assign avs_readdata_out      = st.rdata;
	assign avs_waitrequest_out   = st.avs_wait;
	assign reset_output_n_out    = st.reset_n;
	assign failure_outputs_out   = st.fail_out;
	assign restart_req_out       = st.restart_req;
	assign failsafe_req_out      = st.failsafe_req;
	assign soft_reset_out        = st.soft_rst;
	assign wdog_enabled_out      = st.wd_on;
	assign wdog_start_out        = st.wd_start;
	assign long_window_out       = st.lw_act;
	assign wake_irq_out          = st.wake_irq;
	assign can_rxd_low_out       = st.can_rxd_low;
	assign lin_rxd_low_out       = st.lin_rxd_low;
	assign lin_disable_out       = st.lin_dis;
	assign aux_regulator_off_out = st.aux_off;
	assign main_rail_sc_en_out   = st.sc_en;

endmodule // sws_supervisor

`default_nettype wire

// ### verilog/sws_pkg.sv
// Constants and types shared by the supply and watchdog supervisor
package sws_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 20_000_000;  // Core clock rate
	localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
	localparam int unsigned LONG_WINDOW_MS  = 200;         // Long open window
	localparam int unsigned RESET_DELAY_MS  = 10;          // Reset delay, plain default
	localparam int unsigned LONG_WINDOW_CYC = LONG_WINDOW_MS * CYC_PER_MS;
	localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_MS * CYC_PER_MS;
	localparam int          CNT_W           = 23;          // Holds either count

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [4:0] OFS_WAKE_CTRL = 5'h00;  // wake_control_reg
	localparam logic [4:0] OFS_WDOG_CFG  = 5'h04;  // wdog_config_reg
	localparam logic [4:0] OFS_MODE_CTRL = 5'h08;  // Mode control
	localparam logic [4:0] OFS_STATUS    = 5'h0c;  // Sticky flags, write one to clear
	localparam logic [4:0] OFS_STATE     = 5'h10;  // Live state, read only

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int WK_KEY_A_BIT    = 0;  // stop_wd_disable_key_a
	localparam int WK_BUS_START_BIT = 1; // bus_wake_wdog_start_en
	localparam int WK_AUX_KEEP_BIT = 2;  // aux_reg_keep_on_low_supply
	localparam int WD_KEY_B_BIT    = 0;  // stop_wd_disable_key_b
	localparam int WD_TRIG_BIT     = 1;  // Watchdog trigger
	localparam int MC_MODE_LSB     = 0;  // Two-bit mode field
	localparam int MC_OV_RST_BIT   = 2;  // main_rail_high_restart_en
	localparam logic [1:0] SOFT_RESET_CMD = 2'h3;

	// Status flag positions
	localparam int FL_POR       = 0;
	localparam int FL_SUP_LOW   = 1;
	localparam int FL_SW_LOW    = 2;
	localparam int FL_SW_HIGH   = 3;
	localparam int FL_PREWARN   = 4;
	localparam int FL_MAIN_LOW  = 5;
	localparam int FL_LOW_FS    = 6;
	localparam int FL_MAIN_HIGH = 7;

	// ----------------------------------------------------------------
	// Reset value and rail-low fail-safe count
	// ----------------------------------------------------------------
	localparam logic BUS_START_RST = 1'b1;
	localparam logic [2:0] UV_FAILSAFE_CNT = 3'h4;

	// ----------------------------------------------------------------
	// Mode codes from the mode state machine
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_INIT     = 3'h0;
	localparam logic [2:0] MODE_NORMAL   = 3'h1;
	localparam logic [2:0] MODE_STOP     = 3'h2;
	localparam logic [2:0] MODE_SLEEP    = 3'h3;
	localparam logic [2:0] MODE_RESTART  = 3'h4;
	localparam logic [2:0] MODE_FAILSAFE = 3'h5;

	// ----------------------------------------------------------------
	// Asynchronous input vector positions
	// ----------------------------------------------------------------
	localparam int IN_POR     = 0;
	localparam int IN_SUP_UV  = 1;
	localparam int IN_SW_UV   = 2;
	localparam int IN_SW_OV   = 3;
	localparam int IN_WARN    = 4;
	localparam int IN_RAIL_UV = 5;
	localparam int IN_RAIL_OV = 6;
	localparam int IN_CFG     = 7;
	localparam int IN_CAN_WK  = 8;
	localparam int IN_LIN1_WK = 9;
	localparam int IN_LIN2_WK = 10;
	localparam int IN_W       = 11;

	// Reset output sequencer
	typedef enum logic [2:0] {
		RS_HOLD  = 3'b001,
		RS_DELAY = 3'b010,
		RS_RUN   = 3'b100
	} sws_rst_t;

endpackage

// ### test/sws_chk.sv
// Port checker for the supply and watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
module sws_chk import sws_pkg::*; (
	input wire logic            core_clk_in, rst_n_in, avs_read_in, avs_write_in,
	input wire logic            avs_waitrequest_out, reset_output_n_out,
	input wire logic [2:0]      sbc_mode_in,
	input wire logic [IN_W-1:0] monitor_in,
	input wire logic            restart_req_out, failsafe_req_out, soft_reset_out,
	input wire logic            wdog_start_out, long_window_out, wdog_enabled_out,
	input wire logic            wake_irq_out, can_rxd_low_out, lin_disable_out,
	input wire logic [1:0]      lin_rxd_low_out,
	input wire logic            main_rail_sc_en_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_bus_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("bus wait state wrong");
	a_restart_pulse: assert property (restart_req_out |=> !restart_req_out)
		else $error("restart request too long");
	a_failsafe_wins: assert property (failsafe_req_out |-> !restart_req_out)
		else $error("restart beside fail-safe");
	a_soft_pulse: assert property (soft_reset_out |=> !soft_reset_out)
		else $error("soft reset too long");
	a_rail_low_reset: assert property ($rose(monitor_in[IN_RAIL_UV])
		&& sbc_mode_in == MODE_NORMAL
		|-> ##[3:6] !reset_output_n_out) else $error("reset output not driven");
	a_lin_off: assert property (monitor_in[IN_SW_UV] [*6] |-> lin_disable_out)
		else $error("transceiver not disabled");
	a_sc_paused: assert property (monitor_in[IN_SUP_UV] [*6] |-> !main_rail_sc_en_out)
		else $error("short circuit guard active");
	a_start_window: assert property (wdog_start_out
		|-> long_window_out && wdog_enabled_out
		##1 long_window_out [*8]) else $error("long window short");
	a_wake_rxd: assert property (wake_irq_out |-> can_rxd_low_out || (|lin_rxd_low_out))
		else $error("receive output not low");
endmodule // sws_chk
bind sws_supervisor sws_chk i_chk (.core_clk_in, .rst_n_in, .avs_read_in, .avs_write_in,
	.avs_waitrequest_out, .reset_output_n_out, .sbc_mode_in, .monitor_in, .restart_req_out,
	.failsafe_req_out, .soft_reset_out, .wdog_start_out, .long_window_out, .wdog_enabled_out,
	.wake_irq_out, .can_rxd_low_out, .lin_disable_out, .lin_rxd_low_out, .main_rail_sc_en_out);
`default_nettype wire

// ### test/sws_host.sv
// Host model: register master and stop preparation
`timescale 1ns/1ps
`default_nettype none
module sws_host import sws_pkg::*; (
	input  wire logic        clk_in,
	input  wire logic        waitrequest_in,
	input  wire logic [31:0] readdata_in,
	output var  logic [4:0]  address_out = '0,
	output var  logic        read_out = 1'b0,
	output var  logic        write_out = 1'b0,
	output var  logic [31:0] writedata_out = '0
);
	// Request held until the slave stops waiting
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_in);
		address_out <= a;
		writedata_out <= d;
		write_out <= 1'b1;
		do @(posedge clk_in); while (waitrequest_in !== 1'b0);
		write_out <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_in);
		address_out <= a;
		read_out <= 1'b1;
		do @(posedge clk_in); while (waitrequest_in !== 1'b0);
		d = readdata_in;
		read_out <= 1'b0;
	endtask
	// Key A with wake start enable in one write, then key B
	task automatic wd_off();
		wr(OFS_WAKE_CTRL, 32'h3);
		wr(OFS_WDOG_CFG, 32'h1);
	endtask
	// Clear the overvoltage restart enable before stop
	task automatic pre_stop();
		wr(OFS_MODE_CTRL, 32'h0);
	endtask
endmodule // sws_host
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sws_pkg::*;
	localparam int LW = 50;
	localparam int RD = 20;
	logic clk = 0, rst_n = 0, rdn, wrn, wq, rst_o, fo, rq, fq, sr, wde, ws, lw, irq, can, lnd, aux;
	logic sc;
	logic [2:0] mode = MODE_NORMAL;
	logic [IN_W-1:0] mon = '0;
	logic [4:0] adr;
	logic [31:0] wd, rdd, d;
	logic [1:0] lin;
	int miscompares = 0, compares = 0, nrs = 0, nfs = 0, nsr = 0, n, r0, f0;
	always #25 clk = ~clk;
	// Pulse tallies
	always @(posedge clk) begin
		if (rq === 1'b1) nrs++;
		if (fq === 1'b1) nfs++;
		if (sr === 1'b1) nsr++;
	end
	sws_supervisor #(.LONG_WINDOW_CYCLES(LW), .RESET_DELAY_CYCLES(RD)) i_sws_supervisor (
		.core_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(adr), .avs_read_in(rdn),
		.avs_write_in(wrn), .avs_writedata_in(wd), .avs_readdata_out(rdd),
		.avs_waitrequest_out(wq), .sbc_mode_in(mode), .monitor_in(mon), .reset_output_n_out(rst_o),
		.failure_outputs_out(fo), .restart_req_out(rq), .failsafe_req_out(fq), .soft_reset_out(sr),
		.wdog_enabled_out(wde), .wdog_start_out(ws), .long_window_out(lw), .wake_irq_out(irq),
		.can_rxd_low_out(can), .lin_rxd_low_out(lin), .lin_disable_out(lnd),
		.aux_regulator_off_out(aux), .main_rail_sc_en_out(sc));
	sws_host i_sws_host (.clk_in(clk), .waitrequest_in(wq), .readdata_in(rdd), .address_out(adr),
		.read_out(rdn), .write_out(wrn), .writedata_out(wd));
	task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic rchk(string nm, logic [4:0] a, logic [31:0] m, logic [31:0] e);
		i_sws_host.rd(a, d);
		chk(nm, d & m, e);
	endtask
	task automatic put(int i, logic v);
		@(posedge clk);
		mon[i] <= v;
		repeat (8) @(posedge clk);
	endtask
	task automatic t_sup();
		for (int i = IN_SUP_UV; i <= IN_WARN; i++) begin
			put(i, 1);
			chk("sc on", sc, i != IN_SUP_UV);
			chk("aux off", aux, i == IN_SUP_UV);
			chk("lin off", lnd, i == IN_SW_UV);
			rchk("flag", OFS_STATUS, 32'h1e, 32'h1 << i);
			put(i, 0);
			i_sws_host.wr(OFS_STATUS, 32'h1e);
			rchk("flag clr", OFS_STATUS, 32'h1e, 0);
		end
		$display("test supply done");
	endtask
	task automatic t_wd();
		i_sws_host.wd_off();
		rchk("key b", OFS_WDOG_CFG, 32'h1, 32'h1);
		i_sws_host.pre_stop();
		mode <= MODE_STOP;
		repeat (3) @(posedge clk);
		chk("wd off", wde, 0);
		mon[IN_CAN_WK] <= 1;
		n = 0;
		while (irq !== 1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		chk("rxd low", can & irq, 1);
		chk("wd on", wde, 1);
		n = 0;
		while (lw === 1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk("window", n, LW);
		rchk("keys", OFS_WAKE_CTRL, 32'h1, 0);
		mon[IN_CAN_WK] <= 0;
		mode <= MODE_NORMAL;
		i_sws_host.wr(OFS_WDOG_CFG, 32'h1);
		rchk("bad seq", OFS_WDOG_CFG, 32'h1, 0);
		i_sws_host.wr(OFS_WAKE_CTRL, 32'h3);
		i_sws_host.wr(OFS_WAKE_CTRL, 32'h3);
		rchk("key a", OFS_WAKE_CTRL, 32'h1, 0);
		$display("test watchdog done");
	endtask
	task automatic t_rail();
		put(IN_RAIL_UV, 1);
		put(IN_RAIL_UV, 0);
		rchk("count", OFS_STATE, 32'h380, 32'h80);
		i_sws_host.wr(OFS_STATUS, 32'h20);
		rchk("count clr", OFS_STATE, 32'h380, 0);
		r0 = nrs;
		f0 = nfs;
		repeat (4) begin
			put(IN_RAIL_UV, 1);
			put(IN_RAIL_UV, 0);
		end
		chk("restarts", nrs - r0, 3);
		chk("failsafe", nfs - f0, 1);
		rchk("fs flag", OFS_STATUS, 32'h40, 32'h40);
		rchk("count fs", OFS_STATE, 32'h380, 0);
		r0 = nrs;
		f0 = nfs;
		i_sws_host.wr(OFS_MODE_CTRL, 32'h4);
		mon[IN_CFG] <= 1;
		put(IN_RAIL_OV, 1);
		put(IN_RAIL_OV, 0);
		chk("fail out", fo, 1);
		rchk("ov en", OFS_MODE_CTRL, 32'h4, 0);
		rchk("ov flag", OFS_STATUS, 32'h80, 32'h80);
		i_sws_host.wr(OFS_MODE_CTRL, 32'h4);
		mon[IN_CFG] <= 0;
		put(IN_RAIL_OV, 1);
		put(IN_RAIL_OV, 0);
		chk("ov restart", nrs - r0, 1);
		chk("ov failsafe", nfs - f0, 1);
		r0 = nsr;
		i_sws_host.wr(OFS_WAKE_CTRL, 32'h4);
		i_sws_host.wr(OFS_MODE_CTRL, 32'h3);
		repeat (4) @(posedge clk);
		chk("soft", nsr - r0, 1);
		rchk("defaults", OFS_WAKE_CTRL, 32'h7, 32'h2);
		put(IN_POR, 1);
		put(IN_POR, 0);
		rchk("por", OFS_STATUS, 32'hff, 32'h1);
		$display("test rail done");
	endtask
	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Run bound
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1;
		n = 0;
		while (rst_o !== 1 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		chk("release", n >= RD && rst_o === 1, 1);
		rchk("bus start", OFS_WAKE_CTRL, 32'h2, 32'h2);
		t_sup();
		t_wd();
		t_rail();
		summarize();
	end
endmodule // tb_top
`default_nettype wire
